/* hdl/vcl_params.svh */
// offsets, field positions, reset values and counts of the list-entry block
// assumes inclusion by bare name from the package and the design file
`ifndef VCL_PARAMS_SVH
`define VCL_PARAMS_SVH

// -------------------------------------------------------------------------
// sizes
// -------------------------------------------------------------------------
`define VCL_MAX_ENTRIES      16
`define VCL_NUM_ENTRIES      4
`define VCL_ADDR_W           12
// -------------------------------------------------------------------------
// register offsets
// -------------------------------------------------------------------------
`define VCL_MAINT_STATUS_OFF 12'h010
`define VCL_ENTRY_BASE_OFF   12'h100
`define VCL_ENTRY_STRIDE     12'h004
// -------------------------------------------------------------------------
// list entry fields
// -------------------------------------------------------------------------
`define VCL_HW_BIT           31
`define VCL_GROUP_BIT        30
`define VCL_STATE_HI         29
`define VCL_STATE_LO         28
`define VCL_PRIO_HI          27
`define VCL_PRIO_LO          23
`define VCL_EOI_MAINT_BIT    19
`define VCL_PID_HI           19
`define VCL_PID_LO           10
`define VCL_CPU_HI           12
`define VCL_CPU_LO           10
`define VCL_VID_HI           9
`define VCL_VID_LO           0
`define VCL_ENTRY_WMASK      32'hff8f_ffff
// -------------------------------------------------------------------------
// ids, status bits, reset values
// -------------------------------------------------------------------------
`define VCL_SPURIOUS_ID      10'h3ff
`define VCL_SGI_LAST_ID      10'h00f
`define VCL_PPI_LAST_ID      10'h01f
`define VCL_ENTRY_RESET      32'h0000_0000
`define VCL_STATUS_RESET     8'h00
`endif

/* hdl/vcl_pkg.sv */
// types shared by the list-entry block
// assumes vcl_params.svh sits beside it
`include "vcl_params.svh"
package vcl_pkg;
    // lifecycle state of one entry
    typedef enum logic [1:0] {
        VCL_INACTIVE   = 2'h0,
        VCL_PENDING    = 2'h1,
        VCL_ACTIVE     = 2'h2,
        VCL_ACT_PEND   = 2'h3
    } vcl_state_type;
endpackage

/* hdl/vcl_list_maint.sv */
// list entries of the virtual cpu interface and the maintenance status
// assumes one clock, guest and distributor logic on the same clock
//
// What this block does
// - at most sixteen entries; unimplemented ones RAZ/WI
// - hardware-linked deactivation notifies distributor with physical id
// - deactivate on eoi or deactivate write per mode
// - group bit picks irq/fiq and group enable
// - two-bit state tracks the lifecycle
// - inactive entries skipped except for maintenance
// - five-bit priority; bits 22:20 read zero
// - bit 19 of software entries requests eoi maintenance on deactivate
// - sgi entries return requesting element number
// - hardware entries hold physical id in 19:10
// - physical ids 0-31 target this element's ppi
// - virtual id returned on acknowledge
// - maintenance output needs status bit and enable
// - status register read-only, upper bits zero
// - bit 7: group 1 disabled condition
// - bit 6: group 1 enabled condition
// - bit 5: group 0 disabled condition
// - status bits reset to zero
// - bit 4: group 0 enabled condition
// - bit 3: no entry pending only
// - bit 2: unmatched eoi counter nonzero
// - bit 0: any eoi status bit set
`include "vcl_params.svh"
module vcl_list_maint (
    input  wire logic                     ref_clk_i,
    input  wire logic                     resetn_i,
    // register port
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic [`VCL_ADDR_W-1:0]   reg_addr_i,
    input  wire logic [31:0]              reg_wdata_i,
    output logic      [31:0]              reg_rdata_o,
    output logic      [3:0]               entry_count_field_o,
    // hypervisor controls
    input  wire logic                     vif_global_enable_i,
    input  wire logic                     g1_disabled_maint_en_i,
    input  wire logic                     g1_enabled_maint_en_i,
    input  wire logic                     g0_disabled_maint_en_i,
    input  wire logic                     g0_enabled_maint_en_i,
    input  wire logic                     no_pending_maint_en_i,
    input  wire logic                     entry_missing_maint_en_i,
    input  wire logic                     underflow_maint_en_i,
    input  wire logic [4:0]               unmatched_eoi_counter_i,
    // guest controls
    input  wire logic                     guest_split_eoi_mode_i,
    input  wire logic                     guest_fast_irq_select_i,
    input  wire logic                     guest_group0_enable_i,
    input  wire logic                     guest_group1_enable_i,
    // guest requests
    input  wire logic                     guest_ack_i,
    input  wire logic                     guest_eoi_i,
    input  wire logic                     guest_dir_i,
    input  wire logic [9:0]               guest_intr_id_i,
    output logic                          guest_ack_valid_o,
    output logic      [9:0]               guest_ack_vid_o,
    output logic      [2:0]               guest_ack_cpu_o,
    output logic                          virq_o,
    output logic                          vfiq_o,
    // distributor deactivation
    output logic                          dist_deact_valid_o,
    output logic      [9:0]               dist_deact_id_o,
    output logic                          dist_deact_local_o,
    // maintenance
    output logic      [7:0]               maintenance_status_o,
    output logic                          maint_intr_o
);
    localparam int NUM = `VCL_NUM_ENTRIES;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    // address of entry idx, only implemented ones match
    function automatic logic entry_hit(input logic [`VCL_ADDR_W-1:0] addr, input int idx);
        logic [`VCL_ADDR_W-1:0] off;
        off = `VCL_ENTRY_BASE_OFF + `VCL_ENTRY_STRIDE * idx[`VCL_ADDR_W-1:0];
        return (idx < NUM) && (addr == off);
    endfunction

    // an entry is signalled if pending, its group is enabled and the global enable is set
    function automatic logic entry_live(input logic [31:0] e);
        logic grp_on;
        grp_on = e[`VCL_GROUP_BIT] ? guest_group1_enable_i : guest_group0_enable_i;
        return vif_global_enable_i && grp_on
            && (e[`VCL_STATE_HI:`VCL_STATE_LO] == vcl_pkg::VCL_PENDING);
    endfunction

    // -------------------------------------------------------------------------
    // storage and per-entry strobes
    // -------------------------------------------------------------------------
    // entry words, eoi flags, write and deactivation hits
    logic [31:0]     entry_q [NUM];
    logic [NUM-1:0]  eoi_flag_q;
    logic [NUM-1:0]  wr_hit;
    logic [NUM-1:0]  deact_hit;
    logic [NUM-1:0]  ack_sel;
    logic            deact_req;
    logic [7:0]      status_d;
    logic [7:0]      status_q;

    // implemented entries minus one, fixed
    assign entry_count_field_o = 4'(NUM - 1);
    // deactivation event depends on split mode
    assign deact_req = guest_split_eoi_mode_i ? guest_dir_i : guest_eoi_i;

    // -------------------------------------------------------------------------
    // entry selection
    // -------------------------------------------------------------------------
    // best pending entry for acknowledge, lowest priority value wins
    always_comb begin
        logic        found;
        logic [4:0]  best;
        found   = 1'b0;
        best    = 5'h1f;
        ack_sel = '0;
        for (int i = 0; i < NUM; i++) begin
            if (entry_live(entry_q[i])
                && (!found || entry_q[i][`VCL_PRIO_HI:`VCL_PRIO_LO] < best)) begin
                found   = 1'b1;
                best    = entry_q[i][`VCL_PRIO_HI:`VCL_PRIO_LO];
                ack_sel = '0;
                ack_sel[i] = 1'b1;
            end
        end
    end

    // entry addressed by a register write
    always_comb begin
        for (int i = 0; i < NUM; i++) begin
            wr_hit[i] = reg_wr_i && entry_hit(reg_addr_i, i);
        end
    end

    // active entry whose virtual id matches the deactivation
    always_comb begin
        for (int i = 0; i < NUM; i++) begin
            deact_hit[i] = deact_req && entry_q[i][`VCL_STATE_HI]
                           && (entry_q[i][`VCL_VID_HI:`VCL_VID_LO] == guest_intr_id_i);
        end
    end

    // -------------------------------------------------------------------------
    // entry storage
    // -------------------------------------------------------------------------
    for (genvar g = 0; g < NUM; g++) begin : g_entry
        // software write wins, else lifecycle moves the state
        always_ff @(posedge ref_clk_i) begin
            if (!resetn_i) begin
                entry_q[g] <= `VCL_ENTRY_RESET;
            end else if (wr_hit[g]) begin
                entry_q[g] <= reg_wdata_i & `VCL_ENTRY_WMASK;
            end else if (guest_ack_i && ack_sel[g]) begin
                entry_q[g][`VCL_STATE_HI:`VCL_STATE_LO] <= vcl_pkg::VCL_ACTIVE;
            end else if (deact_hit[g]) begin
                entry_q[g][`VCL_STATE_HI] <= 1'b0;
            end
        end

        // eoi maintenance flag, set wins over clear by a write
        always_ff @(posedge ref_clk_i) begin
            if (!resetn_i) begin
                eoi_flag_q[g] <= 1'b0;
            end else if (deact_hit[g] && !entry_q[g][`VCL_HW_BIT]
                         && entry_q[g][`VCL_EOI_MAINT_BIT]) begin
                eoi_flag_q[g] <= 1'b1;
            end else if (wr_hit[g]) begin
                eoi_flag_q[g] <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // guest side
    // -------------------------------------------------------------------------
    // group 0 as fiq or irq, group 1 always irq
    always_comb begin
        virq_o = 1'b0;
        vfiq_o = 1'b0;
        for (int i = 0; i < NUM; i++) begin
            if (entry_live(entry_q[i])) begin
                if (!entry_q[i][`VCL_GROUP_BIT] && guest_fast_irq_select_i) begin
                    vfiq_o = 1'b1;
                end else begin
                    virq_o = 1'b1;
                end
            end
        end
    end

    // acknowledge answer, spurious id when nothing pending
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            guest_ack_valid_o <= 1'b0;
            guest_ack_vid_o   <= `VCL_SPURIOUS_ID;
            guest_ack_cpu_o   <= 3'h0;
        end else begin
            guest_ack_valid_o <= guest_ack_i;
            if (guest_ack_i) begin
                guest_ack_vid_o <= `VCL_SPURIOUS_ID;
                guest_ack_cpu_o <= 3'h0;
                for (int i = 0; i < NUM; i++) begin
                    if (ack_sel[i]) begin
                        guest_ack_vid_o <= entry_q[i][`VCL_VID_HI:`VCL_VID_LO];
                        if (!entry_q[i][`VCL_HW_BIT]
                            && entry_q[i][`VCL_VID_HI:`VCL_VID_LO] <= `VCL_SGI_LAST_ID) begin
                            guest_ack_cpu_o <= entry_q[i][`VCL_CPU_HI:`VCL_CPU_LO];
                        end
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // distributor side
    // -------------------------------------------------------------------------
    // one-cycle deactivate request for hardware-linked entries
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            dist_deact_valid_o <= 1'b0;
            dist_deact_id_o    <= 10'h000;
            dist_deact_local_o <= 1'b0;
        end else begin
            dist_deact_valid_o <= 1'b0;
            for (int i = 0; i < NUM; i++) begin
                if (deact_hit[i] && entry_q[i][`VCL_HW_BIT]) begin
                    dist_deact_valid_o <= 1'b1;
                    dist_deact_id_o    <= entry_q[i][`VCL_PID_HI:`VCL_PID_LO];
                    dist_deact_local_o <= entry_q[i][`VCL_PID_HI:`VCL_PID_LO]
                                          <= `VCL_PPI_LAST_ID;
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // maintenance status
    // -------------------------------------------------------------------------
    // live conditions
    always_comb begin
        logic       any_pend;
        logic [4:0] valid_cnt;
        any_pend  = 1'b0;
        valid_cnt = 5'h00;
        for (int i = 0; i < NUM; i++) begin
            if (entry_q[i][`VCL_STATE_HI:`VCL_STATE_LO] == vcl_pkg::VCL_PENDING) begin
                any_pend = 1'b1;
            end
            if (entry_q[i][`VCL_STATE_HI:`VCL_STATE_LO] != vcl_pkg::VCL_INACTIVE
                || eoi_flag_q[i]) begin
                valid_cnt = valid_cnt + 5'h01;
            end
        end
        status_d[7] = g1_disabled_maint_en_i && !guest_group1_enable_i;
        status_d[6] = g1_enabled_maint_en_i && guest_group1_enable_i;
        status_d[5] = g0_disabled_maint_en_i && !guest_group0_enable_i;
        status_d[4] = g0_enabled_maint_en_i && guest_group0_enable_i;
        status_d[3] = no_pending_maint_en_i && !any_pend;
        status_d[2] = entry_missing_maint_en_i && (unmatched_eoi_counter_i != 5'h00);
        status_d[1] = underflow_maint_en_i && (valid_cnt <= 5'h01);
        status_d[0] = |eoi_flag_q;
    end

    // status flops, cleared by reset
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            status_q <= `VCL_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // status out; the interrupt also needs the global enable
    assign maintenance_status_o = status_q;
    assign maint_intr_o         = vif_global_enable_i && (|status_q);

    // -------------------------------------------------------------------------
    // register reads
    // -------------------------------------------------------------------------
    // one-cycle read data, unmapped and unimplemented read zero
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= 32'h0000_0000;
            if (reg_addr_i == `VCL_MAINT_STATUS_OFF) begin
                reg_rdata_o <= {24'h00_0000, status_q};
            end
            for (int i = 0; i < NUM; i++) begin
                if (entry_hit(reg_addr_i, i)) begin
                    reg_rdata_o <= entry_q[i];
                end
            end
        end
    end

endmodule // vcl_list_maint

/* sim/vcl_dist_model.sv */
// distributor model that takes deactivation requests from the block
// assumes requests arrive as one-cycle pulses on the block clock
module vcl_dist_model (
    input  wire logic       clk_i,
    input  wire logic       valid_i,
    input  wire logic [9:0] id_i,
    input  wire logic       local_i,
    output int              n_o,
    output logic      [9:0] id_o,
    output logic            local_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int count = 0;
    assign n_o = count;
    // count each deactivation, keep the last physical id and locality
    always @(posedge clk_i) begin
        if (valid_i === 1'h1) begin
            count   <= count + 1;
            id_o    <= id_i;
            local_o <= local_i;
        end
    end
endmodule // vcl_dist_model

/* sim/vcl_list_maint_checker.sv */
// assertions on the ports of the list-entry block
// assumes one clock and the synchronous active-low reset
`include "vcl_params.svh"
module vcl_list_maint_checker (
    input wire logic       ref_clk_i,
    input wire logic       resetn_i,
    input wire logic       vif_global_enable_i,
    input wire logic       g1_disabled_maint_en_i,
    input wire logic       g1_enabled_maint_en_i,
    input wire logic       g0_disabled_maint_en_i,
    input wire logic       g0_enabled_maint_en_i,
    input wire logic       guest_group0_enable_i,
    input wire logic       guest_group1_enable_i,
    input wire logic       guest_split_eoi_mode_i,
    input wire logic       guest_eoi_i,
    input wire logic       guest_dir_i,
    input wire logic       guest_ack_valid_o,
    input wire logic [9:0] guest_ack_vid_o,
    input wire logic       dist_deact_valid_o,
    input wire logic [3:0] entry_count_field_o,
    input wire logic [7:0] maintenance_status_o,
    input wire logic       maint_intr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // ---------------------------------------------------------------
    // maintenance status and output
    // ---------------------------------------------------------------
    chk_maint_out:
        assert property (maint_intr_o == (vif_global_enable_i && (|maintenance_status_o)))
        else $error("maintenance output mismatch");
    chk_g1_dis_bit:
        assert property ($past(resetn_i) |-> maintenance_status_o[7] ==
            ($past(g1_disabled_maint_en_i) && !$past(guest_group1_enable_i)))
        else $error("group 1 disabled bit mismatch");
    chk_g1_ena_bit:
        assert property ($past(resetn_i) |-> maintenance_status_o[6] ==
            ($past(g1_enabled_maint_en_i) && $past(guest_group1_enable_i)))
        else $error("group 1 enabled bit mismatch");
    chk_g0_dis_bit:
        assert property ($past(resetn_i) |-> maintenance_status_o[5] ==
            ($past(g0_disabled_maint_en_i) && !$past(guest_group0_enable_i)))
        else $error("group 0 disabled bit mismatch");
    chk_g0_ena_bit:
        assert property ($past(resetn_i) |-> maintenance_status_o[4] ==
            ($past(g0_enabled_maint_en_i) && $past(guest_group0_enable_i)))
        else $error("group 0 enabled bit mismatch");
    chk_status_rst:
        assert property (disable iff (1'b0) !resetn_i |=> maintenance_status_o == 8'h00)
        else $error("status not cleared by reset");
    // ---------------------------------------------------------------
    // deactivation, acknowledge, entry count
    // ---------------------------------------------------------------
    chk_deact_cause:
        assert property (dist_deact_valid_o |-> ($past(guest_split_eoi_mode_i) ?
            $past(guest_dir_i) : $past(guest_eoi_i)))
        else $error("deactivation without its event");
    chk_spur_ack:
        assert property (guest_ack_valid_o && !$past(vif_global_enable_i) |->
            guest_ack_vid_o == 10'h3ff)
        else $error("acknowledge while disabled not spurious");
    chk_entry_count:
        assert property (entry_count_field_o == 4'(`VCL_NUM_ENTRIES - 1))
        else $error("entry count field mismatch");
endmodule // vcl_list_maint_checker
bind vcl_list_maint vcl_list_maint_checker vcl_list_maint_checker_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .vif_global_enable_i(vif_global_enable_i),
    .g1_disabled_maint_en_i(g1_disabled_maint_en_i), .guest_eoi_i(guest_eoi_i),
    .g1_enabled_maint_en_i(g1_enabled_maint_en_i), .guest_dir_i(guest_dir_i),
    .g0_disabled_maint_en_i(g0_disabled_maint_en_i), .maint_intr_o(maint_intr_o),
    .g0_enabled_maint_en_i(g0_enabled_maint_en_i), .guest_ack_vid_o(guest_ack_vid_o),
    .guest_group0_enable_i(guest_group0_enable_i), .guest_ack_valid_o(guest_ack_valid_o),
    .guest_group1_enable_i(guest_group1_enable_i), .dist_deact_valid_o(dist_deact_valid_o),
    .guest_split_eoi_mode_i(guest_split_eoi_mode_i), .entry_count_field_o(entry_count_field_o),
    .maintenance_status_o(maintenance_status_o));

/* sim/vcl_list_maint_tb.sv */
// self-checking testbench of the list-entry block with a distributor model
// assumes design, package, model and checker files compiled before it
`include "vcl_params.svh"
module vcl_list_maint_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 1'h0;
    logic        resetn_i  = 1'h0;
    logic        wr = 1'h0, rd = 1'h0, ven = 1'h0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [6:0]  men = 7'h00;  // g1d g1e g0d g0e np em uf enables
    logic [3:0]  gc = 4'h0;    // split, fiq, group 0 enable, group 1 enable
    logic [4:0]  cnt = 5'h00;
    logic [2:0]  greq = 3'h0;  // dir, eoi, ack
    logic [9:0]  gid = 10'h000, avid, did, mid;
    logic [2:0]  acpu;
    logic [7:0]  mstat;
    logic [3:0]  ecount;
    logic        avalid, virq, vfiq, dvalid, dlocal, mint, mlocal;
    int          num_errors = 0, n_tests = 0, mcount;
    always #50 ref_clk_i = ~ref_clk_i;
    vcl_list_maint vcl_list_maint_inst (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .entry_count_field_o(ecount), .vif_global_enable_i(ven),
        .g1_disabled_maint_en_i(men[6]), .g1_enabled_maint_en_i(men[5]),
        .g0_disabled_maint_en_i(men[4]), .g0_enabled_maint_en_i(men[3]),
        .no_pending_maint_en_i(men[2]), .entry_missing_maint_en_i(men[1]),
        .underflow_maint_en_i(men[0]), .unmatched_eoi_counter_i(cnt),
        .guest_split_eoi_mode_i(gc[3]), .guest_fast_irq_select_i(gc[2]),
        .guest_group0_enable_i(gc[1]), .guest_group1_enable_i(gc[0]),
        .guest_ack_i(greq[0]), .guest_eoi_i(greq[1]), .guest_dir_i(greq[2]),
        .guest_intr_id_i(gid), .guest_ack_valid_o(avalid), .guest_ack_vid_o(avid),
        .guest_ack_cpu_o(acpu), .virq_o(virq), .vfiq_o(vfiq), .dist_deact_valid_o(dvalid),
        .dist_deact_id_o(did), .dist_deact_local_o(dlocal),
        .maintenance_status_o(mstat), .maint_intr_o(mint));
    vcl_dist_model vcl_dist_model_inst (.clk_i(ref_clk_i), .valid_i(dvalid), .id_i(did),
        .local_i(dlocal), .n_o(mcount), .id_o(mid), .local_o(mlocal));
    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        @(negedge ref_clk_i) {wr, addr, wdata} = {1'h1, a, d};
        @(negedge ref_clk_i) wr = 1'h0;
    endtask
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        @(negedge ref_clk_i) {rd, addr} = {1'h1, a};
        @(negedge ref_clk_i) rd = 1'h0;
        chk(n, rdata, e);
    endtask
    task automatic guest(input logic [2:0] k, input logic [9:0] id);
        @(negedge ref_clk_i) {greq, gid} = {k, id};
        @(negedge ref_clk_i) greq = 3'h0;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        num_errors++;
        report_and_stop();
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        tick(20);
        resetn_i = 1'h1;
        rdc("status reset", 12'h010, 32'h0);
        chk("entry count", ecount, `VCL_NUM_ENTRIES - 1);
        wr32(12'h010, 32'hffff_ffff);
        rdc("status ro", 12'h010, 32'h0);
        wr32(12'h100, 32'hafff_7fe0);
        rdc("entry reserved", 12'h100, 32'haf8f_7fe0);
        wr32(12'h110, 32'h1234_5678);
        rdc("entry 4", 12'h110, 32'h0);
        rdc("entry 15", 12'h13c, 32'h0);
        wr32(12'h100, 32'h0);
        {ven, men} = {1'h1, 7'h78};
        for (int j = 0; j < 4; j++) begin
            gc = 4'(j);
            tick(1);
            chk("group status", mstat[7:4], {~j[0], j[0], ~j[1], j[1]});
            chk("maint out", mint, 1'h1);
        end
        ven = 1'h0;
        tick(1);
        chk("maint disabled", mint, 1'h0);
        {ven, men, cnt} = {1'h1, 7'h02, 5'h1f};
        tick(1);
        chk("missing status", mstat, 8'h04);
        {men, cnt} = {7'h05, 5'h00};
        tick(1);
        chk("empty status", mstat, 8'h0a);
        wr32(12'h100, 32'h5280_0c05);
        tick(1);
        chk("one entry", mstat, 8'h02);
        wr32(12'h104, 32'h9100_8040);
        tick(1);
        chk("two entries", mstat, 8'h00);
        gc = 4'h7;
        tick(1);
        chk("irq fiq", {virq, vfiq}, 2'h3);
        gc = 4'h2;
        tick(1);
        chk("group 0 irq", {virq, vfiq}, 2'h2);
        gc = 4'h4;
        tick(1);
        chk("both off", {virq, vfiq}, 2'h0);
        gc = 4'h3;
        guest(3'h1, 10'h000);
        chk("ack prio", {avalid, avid, acpu}, {1'h1, 10'h040, 3'h0});
        guest(3'h1, 10'h000);
        chk("ack cpu", {avid, acpu}, {10'h005, 3'h3});
        guest(3'h1, 10'h000);
        chk("none pending", avid, 10'h3ff);
        rdc("entry0 active", 12'h100, 32'h6280_0c05);
        rdc("entry1 active", 12'h104, 32'ha100_8040);
        gc = 4'hb;
        guest(3'h2, 10'h040);
        tick(1);
        chk("split eoi", mcount, 0);
        guest(3'h4, 10'h040);
        tick(1);
        chk("dir deact", {mcount[3:0], mid, mlocal}, {4'h1, 10'h020, 1'h0});
        rdc("entry1 idle", 12'h104, 32'h8100_8040);
        gc = 4'h3;
        guest(3'h2, 10'h005);
        tick(1);
        chk("soft eoi", mcount, 1);
        rdc("entry0 idle", 12'h100, 32'h4280_0c05);
        wr32(12'h104, 32'ha100_7c40);
        guest(3'h4, 10'h040);
        tick(1);
        chk("dir ignored", mcount, 1);
        guest(3'h2, 10'h040);
        tick(1);
        chk("own ppi", {mcount[3:0], mid, mlocal}, {4'h2, 10'h01f, 1'h1});
        men = 7'h00;
        wr32(12'h108, 32'h2008_0030);
        guest(3'h2, 10'h030);
        tick(1);
        chk("eoi maint", mstat, 8'h01);
        wr32(12'h108, 32'h0);
        tick(1);
        chk("eoi cleared", mstat, 8'h00);
        wr32(12'h100, 32'h5280_0c05);
        ven = 1'h0;
        guest(3'h1, 10'h000);
        chk("spurious", avid, 10'h3ff);
        // second reset while status bits stand
        {ven, men} = {1'h1, 7'h78};
        tick(1);
        chk("before reset", mstat, 8'h50);
        resetn_i = 1'h0;
        tick(1);
        chk("reset status", {mstat, mint}, 9'h000);
        resetn_i = 1'h1;
        tick(1);
        chk("after reset", mstat, 8'h50);
        report_and_stop();
    end
endmodule // vcl_list_maint_tb
